// *** coupler_status_led_driver.sv ***
// lamp pattern generator and decoder for the coupler diagnostics
`timescale 1ns/1ps
`include "coupler_led_map.svh"

// Functional notes
// - init state keeps state lamp dark
// - pre-operational state blinks state lamp regularly
// - safe-operational gives repeating single short flash
// - operational state keeps state lamp lit
// - incoming lamp dark without incoming link
// - incoming lamp steady when linked, idle
// - incoming lamp blinks during incoming traffic
// - outgoing lamp dark without outgoing link
// - outgoing lamp steady when linked, idle
// - outgoing lamp blinks during outgoing traffic
// - backplane lamp dark without backplane connection
// - backplane lamp steady when connected, blinks active
module coupler_status_led_driver #(
    parameter int TICK_CYCLES =
        `LED_TICK_MS * (`LED_CLK_HZ / 1000)
)
(
    // clock, reset, enable
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic ce,
    // protocol and port status, same clock domain
    input wire coupler_led_pkg::esmState_t stateCode,
    input wire coupler_led_pkg::portFlags_t [`LED_NUM_PORTS-1:0] portFlags,
    // lamp drive, high lights the lamp
    output coupler_led_pkg::lampDrive_t lamps
);

    localparam int TICK_W = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
    localparam int PHASE_W = $clog2(`LED_PHASE_TICKS);

    // pattern timebase
    logic [TICK_W-1:0] tickCnt;
    logic [TICK_W-1:0] next_tickCnt;
    logic [PHASE_W-1:0] phase;
    logic [PHASE_W-1:0] next_phase;
    logic flickerPat;
    logic next_flickerPat;
    logic tick;
    logic blinkPat;
    logic flashPat;

    assign tick = (tickCnt == TICK_W'(TICK_CYCLES - 1));
    // derived from one frame counter so the shapes stay phase locked
    assign blinkPat = ~phase[`LED_BLINK_BIT];
    assign flashPat = (phase < PHASE_W'(`LED_FLASH_TICKS));

    always_comb
    begin
        next_tickCnt = tickCnt;
        next_phase = phase;
        next_flickerPat = flickerPat;
        if (ce)
        begin
            if (tick)
            begin
                next_tickCnt = '0;
                // flicker toggles every tick: four times the blink rate
                next_flickerPat = ~flickerPat;
                if (phase == PHASE_W'(`LED_PHASE_TICKS - 1))
                begin
                    next_phase = '0;
                end
                else
                begin
                    next_phase = phase + 1'b1;
                end
            end
            else
            begin
                next_tickCnt = tickCnt + 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            tickCnt <= '0;
            phase <= '0;
            flickerPat <= 1'b0;
        end
        else
        begin
            tickCnt <= next_tickCnt;
            phase <= next_phase;
            flickerPat <= next_flickerPat;
        end
    end

    // state lamp mode decode
    coupler_led_pkg::runMode_t runMode;
    logic next_run;
    logic runLamp;

    always_comb
    begin
        unique case (stateCode)
            `ESM_INIT: runMode = coupler_led_pkg::MODE_OFF;
            `ESM_PREOP: runMode = coupler_led_pkg::MODE_BLINK;
            `ESM_SAFEOP: runMode = coupler_led_pkg::MODE_FLASH;
            `ESM_OP: runMode = coupler_led_pkg::MODE_ON;
            `ESM_BOOT: runMode = coupler_led_pkg::MODE_FLICKER;
            // unknown codes stay dark rather than guess a state
            default: runMode = coupler_led_pkg::MODE_OFF;
        endcase
    end

    always_comb
    begin
        unique case (runMode)
            coupler_led_pkg::MODE_OFF: next_run = 1'b0;
            coupler_led_pkg::MODE_BLINK: next_run = blinkPat;
            coupler_led_pkg::MODE_FLASH: next_run = flashPat;
            coupler_led_pkg::MODE_ON: next_run = 1'b1;
            coupler_led_pkg::MODE_FLICKER: next_run = flickerPat;
            default: next_run = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            runLamp <= 1'b0;
        end
        else if (ce)
        begin
            runLamp <= next_run;
        end
    end

    // port lamps: incoming, outgoing, backplane
    logic [`LED_NUM_PORTS-1:0] actHeld;
    logic [`LED_NUM_PORTS-1:0] portLamp;

    // one driver for the whole output struct, fields come from flops
    assign lamps = {runLamp, portLamp};

    genvar gp;
    generate
        for (gp = 0; gp < `LED_NUM_PORTS; gp++)
        begin : g_port
            logic [2:0] actCnt;
            logic [2:0] next_actCnt;
            logic next_lamp;
            logic lit;

            assign actHeld[gp] = (actCnt != 3'h0);
            assign portLamp[gp] = lit;

            // a frame pulse may be one cycle; stretch it so it shows
            always_comb
            begin
                next_actCnt = actCnt;
                if (ce)
                begin
                    if (portFlags[gp].link && portFlags[gp].act)
                    begin
                        // a new pulse wins over the tick decrement
                        next_actCnt = 3'(`LED_ACT_HOLD_TICKS);
                    end
                    else if (!portFlags[gp].link)
                    begin
                        next_actCnt = 3'h0;
                    end
                    else if (tick && actHeld[gp])
                    begin
                        next_actCnt = actCnt - 1'b1;
                    end
                end
            end

            always_comb
            begin
                if (!portFlags[gp].link)
                begin
                    next_lamp = 1'b0;
                end
                else if (portFlags[gp].act || actHeld[gp])
                begin
                    next_lamp = blinkPat;
                end
                else
                begin
                    next_lamp = 1'b1;
                end
            end

            always_ff @(posedge core_clk)
            begin
                if (!rst_b)
                begin
                    actCnt <= 3'h0;
                    lit <= 1'b0;
                end
                else if (ce)
                begin
                    actCnt <= next_actCnt;
                    lit <= next_lamp;
                end
            end

            property p_port_dark;
                @(posedge core_clk) disable iff (!rst_b)
                (ce && !portFlags[gp].link) |=> !lamps.port[gp];
            endproperty
            a_port_dark: assert property (p_port_dark)
                else $error("port lamp lit without link");

            property p_port_steady;
                @(posedge core_clk) disable iff (!rst_b)
                (ce && portFlags[gp].link && !portFlags[gp].act
                    && !actHeld[gp]) |=> lamps.port[gp];
            endproperty
            a_port_steady: assert property (p_port_steady)
                else $error("linked idle port lamp not lit");

            property p_port_blink;
                @(posedge core_clk) disable iff (!rst_b)
                (ce && portFlags[gp].link && portFlags[gp].act)
                    |=> lamps.port[gp] == $past(blinkPat);
            endproperty
            a_port_blink: assert property (p_port_blink)
                else $error("active port lamp not following blink");

            property p_act_stretch;
                @(posedge core_clk) disable iff (!rst_b)
                (ce && portFlags[gp].link && portFlags[gp].act)
                    |=> actCnt == 3'(`LED_ACT_HOLD_TICKS);
            endproperty
            a_act_stretch: assert property (p_act_stretch)
                else $error("activity stretch not reloaded");

            c_port_active: cover property (@(posedge core_clk)
                disable iff (!rst_b)
                portFlags[gp].link ##1 portFlags[gp].act ##1 actHeld[gp]);
        end
    endgenerate

    // checks on the state lamp and timebase
    property p_init_dark;
        @(posedge core_clk) disable iff (!rst_b)
        (ce && stateCode == `ESM_INIT) |=> !lamps.run;
    endproperty
    a_init_dark: assert property (p_init_dark)
        else $error("state lamp lit in init");

    property p_preop_blink;
        @(posedge core_clk) disable iff (!rst_b)
        (ce && stateCode == `ESM_PREOP) |=> lamps.run == $past(blinkPat);
    endproperty
    a_preop_blink: assert property (p_preop_blink)
        else $error("state lamp not blinking in pre-operational");

    property p_safeop_flash;
        @(posedge core_clk) disable iff (!rst_b)
        (ce && stateCode == `ESM_SAFEOP) |=> lamps.run == $past(flashPat);
    endproperty
    a_safeop_flash: assert property (p_safeop_flash)
        else $error("state lamp not single flashing in safe-operational");

    property p_op_on;
        @(posedge core_clk) disable iff (!rst_b)
        (ce && stateCode == `ESM_OP) |=> lamps.run;
    endproperty
    a_op_on: assert property (p_op_on)
        else $error("state lamp dark in operational");

    property p_boot_flicker;
        @(posedge core_clk) disable iff (!rst_b)
        (ce && stateCode == `ESM_BOOT) |=> lamps.run == $past(flickerPat);
    endproperty
    a_boot_flicker: assert property (p_boot_flicker)
        else $error("state lamp not flickering in bootstrap");

    property p_flicker_toggle;
        @(posedge core_clk) disable iff (!rst_b)
        (ce && tick) |=> flickerPat != $past(flickerPat);
    endproperty
    a_flicker_toggle: assert property (p_flicker_toggle)
        else $error("flicker did not toggle on tick");

    property p_timebase;
        @(posedge core_clk) disable iff (!rst_b)
        tickCnt <= TICK_W'(TICK_CYCLES - 1)
            && phase <= PHASE_W'(`LED_PHASE_TICKS - 1);
    endproperty
    a_timebase: assert property (p_timebase)
        else $error("pattern counters out of range");

    property p_phase_wrap;
        @(posedge core_clk) disable iff (!rst_b)
        (ce && tick && phase == PHASE_W'(`LED_PHASE_TICKS - 1))
            |=> phase == '0;
    endproperty
    a_phase_wrap: assert property (p_phase_wrap)
        else $error("pattern frame did not wrap");

    property p_freeze;
        @(posedge core_clk) disable iff (!rst_b)
        !ce |=> tickCnt == $past(tickCnt) && lamps == $past(lamps);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("state moved while clock enable low");

    c_preop: cover property (@(posedge core_clk) disable iff (!rst_b)
        stateCode == `ESM_PREOP && lamps.run);
    c_safeop: cover property (@(posedge core_clk) disable iff (!rst_b)
        stateCode == `ESM_SAFEOP && tick && flashPat);
    c_boot: cover property (@(posedge core_clk) disable iff (!rst_b)
        stateCode == `ESM_BOOT && tick);

endmodule

// *** coupler_led_map.svh ***
// constants for the coupler status lamp driver
`ifndef COUPLER_LED_MAP_SVH
`define COUPLER_LED_MAP_SVH

// system clock
`define LED_CLK_HZ 40000000
// base pattern tick, milliseconds
`define LED_TICK_MS 50
// pattern frame length in ticks (1200 ms)
`define LED_PHASE_TICKS 24
// phase bit that gives 200 ms on / 200 ms off
`define LED_BLINK_BIT 2
// single flash: lit for the first ticks of a frame
`define LED_FLASH_TICKS 4
// activity stretch in ticks after the last frame pulse
`define LED_ACT_HOLD_TICKS 4
// lamp ports: 0 incoming, 1 outgoing, 2 backplane
`define LED_NUM_PORTS 3
`define LED_PORT_IN 0
`define LED_PORT_OUT 1
`define LED_PORT_BP 2

// state machine codes as reported by the protocol logic
`define ESM_INIT 4'h1
`define ESM_PREOP 4'h2
`define ESM_BOOT 4'h3
`define ESM_SAFEOP 4'h4
`define ESM_OP 4'h8

`endif

// *** coupler_led_pkg.sv ***
// types for the coupler status lamp driver
package coupler_led_pkg;

    typedef logic [3:0] esmState_t;

    typedef enum logic [4:0] {
        MODE_OFF = 5'h01,
        MODE_BLINK = 5'h02,
        MODE_FLASH = 5'h04,
        MODE_ON = 5'h08,
        MODE_FLICKER = 5'h10
    } runMode_t;

    typedef struct packed {
        logic link;
        logic act;
    } portFlags_t;

    typedef struct packed {
        logic run;
        logic [2:0] port;
    } lampDrive_t;

endpackage

// *** coupler_port_model.sv ***
// far-side port logic: link levels and frame activity pulses
`timescale 1ns/1ps
`include "coupler_led_map.svh"
module coupler_port_model (
    // clock
    input wire logic core_clk,
    // scenario control from the bench
    input wire logic [2:0] linkReq,
    input wire logic [2:0] trafficReq,
    // flags toward the lamp driver
    output coupler_led_pkg::portFlags_t [`LED_NUM_PORTS-1:0] portFlags
);
    int gap = 0;
    initial portFlags = '0;
    // one-cycle frame pulses; act still pulses without link, to tempt the lamp
    always @(posedge core_clk)
    begin
        gap <= (gap == 4) ? 0 : gap + 1;
        for (int i = 0; i < `LED_NUM_PORTS; i++)
        begin
            portFlags[i].link <= linkReq[i];
            portFlags[i].act <= trafficReq[i] && gap == 0;
        end
    end
endmodule

// *** test_coupler_status_led_driver.sv ***
// self-checking bench for the coupler status lamp driver
`timescale 1ns/1ps
`include "coupler_led_map.svh"
module test_coupler_status_led_driver;
    localparam int TICK = 4;
    localparam int WIN = TICK * `LED_PHASE_TICKS;
    localparam coupler_led_pkg::runMode_t offMode =
        coupler_led_pkg::MODE_OFF;
    localparam coupler_led_pkg::runMode_t blinkMode =
        coupler_led_pkg::MODE_BLINK;
    localparam coupler_led_pkg::runMode_t onMode =
        coupler_led_pkg::MODE_ON;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic ce = 1'b1;
    coupler_led_pkg::esmState_t stateCode = `ESM_INIT;
    logic [2:0] linkReq = 3'h0;
    logic [2:0] trafficReq = 3'h0;
    coupler_led_pkg::portFlags_t [`LED_NUM_PORTS-1:0] portFlags;
    coupler_led_pkg::lampDrive_t lamps;
    coupler_led_pkg::esmState_t codes[6] = '{`ESM_INIT, `ESM_PREOP,
        `ESM_SAFEOP, `ESM_OP, `ESM_BOOT, 4'hf};
    coupler_led_pkg::runMode_t modes[6] = '{coupler_led_pkg::MODE_OFF,
        coupler_led_pkg::MODE_BLINK, coupler_led_pkg::MODE_FLASH,
        coupler_led_pkg::MODE_ON, coupler_led_pkg::MODE_FLICKER,
        coupler_led_pkg::MODE_OFF};
    int err_count = 0;
    int comparisons = 0;
    int seed = 31039;
    int highs;
    int edges;
    int idx;
    logic prev;
    logic snap;

    always #12.5 core_clk = ~core_clk;

    coupler_status_led_driver #(.TICK_CYCLES(TICK)) uut (
        .core_clk(core_clk), .rst_b(rst_b), .ce(ce),
        .stateCode(stateCode), .portFlags(portFlags), .lamps(lamps));

    coupler_port_model peer (.core_clk(core_clk), .linkReq(linkReq),
        .trafficReq(trafficReq), .portFlags(portFlags));

    // lit cycles over one full pattern frame, independent of phase
    function automatic int expHigh(coupler_led_pkg::runMode_t m);
        case (m)
            coupler_led_pkg::MODE_ON: return WIN;
            coupler_led_pkg::MODE_BLINK: return WIN / 2;
            coupler_led_pkg::MODE_FLICKER: return WIN / 2;
            coupler_led_pkg::MODE_FLASH: return `LED_FLASH_TICKS * TICK;
            default: return 0;
        endcase
    endfunction

    function automatic int expEdges(coupler_led_pkg::runMode_t m);
        case (m)
            coupler_led_pkg::MODE_BLINK:
                return 2 * `LED_PHASE_TICKS / (2 << `LED_BLINK_BIT);
            coupler_led_pkg::MODE_FLASH: return 2;
            coupler_led_pkg::MODE_FLICKER: return `LED_PHASE_TICKS;
            default: return 0;
        endcase
    endfunction

    // sel 3 is the state lamp, 0..2 the port lamps
    function automatic logic pick(int sel);
        return (sel == 3) ? lamps.run : lamps.port[sel];
    endfunction

    // port lamp mode from the levels asked of the port model
    function automatic coupler_led_pkg::runMode_t expPort(int p);
        if (!linkReq[p])
            return offMode;
        if (trafficReq[p])
            return blinkMode;
        return onMode;
    endfunction

    task automatic check(string name, int sel,
        coupler_led_pkg::runMode_t m, int settle);
        highs = 0;
        edges = 0;
        repeat (settle) @(negedge core_clk);
        prev = pick(sel);
        repeat (WIN)
        begin
            @(negedge core_clk);
            snap = pick(sel);
            if (snap === 1'b1)
                highs++;
            else if (snap !== 1'b0)
                highs += 1000;
            if (snap !== prev)
                edges++;
            prev = snap;
        end
        comparisons++;
        if (highs != expHigh(m) || edges != expEdges(m))
        begin
            err_count++;
            $display("[FAIL] %s expected %0d/%0d seen %0d/%0d", name,
                expHigh(m), expEdges(m), highs, edges);
        end
        $display("test %s done", name);
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        #(25 * 100000);
        err_count++;
        summarize();
    end

    initial
    begin
        repeat (8) @(posedge core_clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 6; i++)
        begin
            @(posedge core_clk);
            stateCode <= codes[i];
            check("state lamp", 3, modes[i], 3);
        end
        for (int p = 0; p < 3; p++)
        begin
            @(posedge core_clk);
            trafficReq[p] <= 1'b1;
            check("port dark", p, offMode, 3);
            @(posedge core_clk);
            linkReq[p] <= 1'b1;
            // first pulse after link may lag by a whole pulse gap
            check("port busy", p, blinkMode, 8);
            @(posedge core_clk);
            trafficReq[p] <= 1'b0;
            check("port idle", p, onMode, 24);
            @(posedge core_clk);
            linkReq[p] <= 1'b0;
        end
        // random link, traffic and state mixes
        repeat (12)
        begin
            @(posedge core_clk);
            idx = $unsigned($random(seed)) % 6;
            stateCode <= codes[idx];
            linkReq <= 3'($random(seed));
            trafficReq <= 3'($random(seed));
            check("rand state", 3, modes[idx], 24);
            check("rand in", 0, expPort(0), 3);
            check("rand out", 1, expPort(1), 3);
            check("rand bp", 2, expPort(2), 3);
        end
        // frozen enable must hold a flickering lamp still
        @(posedge core_clk);
        stateCode <= `ESM_BOOT;
        repeat (10) @(posedge core_clk);
        ce <= 1'b0;
        @(negedge core_clk);
        prev = lamps.run;
        repeat (20)
        begin
            @(negedge core_clk);
            comparisons++;
            if (lamps.run !== prev)
            begin
                err_count++;
                $display("[FAIL] frozen lamp expected %b seen %b", prev,
                    lamps.run);
            end
        end
        $display("test enable freeze done");
        @(posedge core_clk);
        ce <= 1'b1;
        stateCode <= `ESM_OP;
        linkReq <= 3'h7;
        repeat (30) @(posedge core_clk);
        rst_b <= 1'b0;
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        comparisons++;
        if (lamps !== 4'h0)
        begin
            err_count++;
            $display("[FAIL] reset lamps expected 0 seen %h", lamps);
        end
        $display("test reset done");
        @(posedge core_clk);
        rst_b <= 1'b1;
        check("after reset", 3, coupler_led_pkg::MODE_ON, 3);
        summarize();
    end
endmodule
